/* File: channel_clock_divider_pkg.sv */
`default_nettype none
package channel_clock_divider_pkg;

    // ------------------------------------------------------------------
    // structure
    // ------------------------------------------------------------------
    localparam int NUM_STAGES = 7;
    localparam int NUM_CHANS  = 5;
    localparam int IDX_W      = 9;
    localparam int ADR_W      = 11;

    // divider stages that see the distribution clock directly
    localparam logic [NUM_STAGES-1:0] FIRST_STAGE_MASK = 7'h2f;
    // channel that owns each stage
    localparam int STAGE_CHAN [NUM_STAGES] = '{0, 1, 2, 3, 3, 4, 4};
    // last stage of each channel, which drives the channel output
    localparam int CHAN_LAST [NUM_CHANS] = '{0, 1, 2, 4, 6};

    // ------------------------------------------------------------------
    // register indices (byte address = 4 x index)
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] COUNT_IDX [NUM_STAGES] =
        '{9'h190, 9'h193, 9'h196, 9'h199, 9'h19b, 9'h19e, 9'h1a0};
    localparam logic [IDX_W-1:0] PHASE_IDX [NUM_CHANS] =
        '{9'h191, 9'h194, 9'h197, 9'h1f0, 9'h1f1};
    localparam logic [IDX_W-1:0] DUTY_IDX [NUM_CHANS] =
        '{9'h192, 9'h195, 9'h198, 9'h19d, 9'h1a2};
    localparam logic [IDX_W-1:0] CASC_BYPASS_IDX [2] = '{9'h19c, 9'h1a1};
    localparam logic [IDX_W-1:0] IDX_SOURCE_SELECT = 9'h1e1;
    localparam logic [IDX_W-1:0] IDX_ALIGN_CONTROL = 9'h1f2;
    localparam logic [IDX_W-1:0] IDX_OUTPUT_ENABLE = 9'h1f3;
    localparam logic [IDX_W-1:0] IDX_STATUS        = 9'h1f4;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_BYPASS           = 7;
    localparam int BIT_BEGIN_HIGH       = 4;
    localparam int BIT_STAGE1_BYPASS    = 4;
    localparam int BIT_STAGE2_BYPASS    = 5;
    localparam int BIT_DUTY_FIX_DISABLE = 0;
    localparam int BIT_ALIGN_TRIGGER    = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_COUNTS      = 8'h00;
    localparam logic [7:0] RST_PHASE       = 8'h00;
    localparam logic [7:0] RST_CASC_BYPASS = 8'h00;
    localparam logic       RST_DUTY_OFF    = 1'h0;
    localparam logic [1:0] RST_OUT_ENABLE  = 2'h0;

    // divider input source selector
    typedef enum logic [1:0] {
        SRC_CLK_VIA_VCODIV = 2'b00,
        SRC_CLK_DIRECT     = 2'b01,
        SRC_VCO_VIA_VCODIV = 2'b10,
        SRC_FORBIDDEN      = 2'b11
    } source_sel_t;

    localparam source_sel_t RST_SOURCE = SRC_VCO_VIA_VCODIV;

endpackage : channel_clock_divider_pkg
`default_nettype wire

/* File: channel_clock_divider.sv */
// The Wishbone register port was left to the implementer.
`default_nettype none
// Overview of operation
// - each stage holds 4-bit low and high fields; phases last field plus one cycles
// - unbypassed single stage divides by both fields plus two, ratio 2 to 32
// - bypass passes input at ratio one and freezes the counter
// - single-stage fields at first register, bypass bit 7, duty disable bit 0
// - counts are cycles of the divider input clock
// - duty correction on after reset, disabled per channel by its bit
// - duty correction gives 50%; software sets equal or low-plus-one fields; odd ratios come out one cycle longer low than high
// - uncorrected output is high for high cycles over total cycles
// - phase_skip plus begin_high form a five-bit delay, begin_high weighs 16
// - delay up to 15 delays the rising edge by that many cycles
// - delay of 16 or more delays by value minus 16 plus low cycles
// - new phase offsets apply only at an alignment event
// - begin_high bit 4 and phase_skip bits 3:0 of second register
// - cascaded channels chain two 2-to-32 stages, product up to 1024
// - cascaded bypass bits 4 and 5, one duty disable bit serves both
// - both bypassed gives ratio 1; second bypassed gives first ratio
// - cascaded ratio only reaches products of the two stage ratios
// - second single-ended output of cascaded pairs off after reset
// - two-bit source selector, fourth code forbidden
// - each output can begin high or low after alignment, a cascaded one only with its second stage bypassed
module channel_clock_divider
    import channel_clock_divider_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [ADR_W-1:0]      wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  alignTrigger,
    output logic      [NUM_CHANS-1:0]  chanOut,
    output logic      [1:0]            chanOutB,
    output logic      [1:0]            sourceSel
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // split a ratio into high and low lengths; with duty fix on, the
    // split comes from the total so even ratios are exactly 50% whatever the fields
    function automatic logic [9:0] ratioSplit(input logic [7:0] counts,
                                              input logic       dutyOn);
        logic [5:0] total;
        logic [4:0] hi;
        logic [4:0] lo;
        total = 6'({2'b00, counts[7:4]}) + 6'({2'b00, counts[3:0]}) + 6'h02;
        if (dutyOn) begin
            hi = total[5:1];
            lo = 5'(total - {1'b0, total[5:1]});
        end else begin
            hi = 5'({1'b0, counts[3:0]}) + 5'h01;
            lo = 5'({1'b0, counts[7:4]}) + 5'h01;
        end
        return {hi, lo};
    endfunction : ratioSplit

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0]            countsReg_ff [NUM_STAGES];
    logic [7:0]            phaseReg_ff  [NUM_CHANS];
    logic [7:0]            cascByp_ff   [2];
    logic [NUM_CHANS-1:0]  dutyOff_ff;
    logic [1:0]            outEnB_ff;
    source_sel_t           srcSel_ff;
    logic                  ack_ff;
    logic [31:0]           datO_ff;
    logic                  syncReq_ff;

    // divider state
    logic [4:0]            cnt_ff   [NUM_STAGES];
    logic                  out_ff   [NUM_STAGES];
    logic [4:0]            actHi_ff [NUM_STAGES];
    logic [4:0]            actLo_ff [NUM_STAGES];
    logic [NUM_STAGES-1:0] actByp_ff;
    logic [NUM_CHANS-1:0]  chanOut_ff;
    logic [1:0]            chanOutB_ff;

    logic [4:0]            nxt_cnt   [NUM_STAGES];
    logic                  nxt_out   [NUM_STAGES];
    logic [4:0]            nxt_actHi [NUM_STAGES];
    logic [4:0]            nxt_actLo [NUM_STAGES];
    logic [NUM_STAGES-1:0] nxt_actByp;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire logic [IDX_W-1:0] wbIdx   = wb_adr_i[ADR_W-1:2];
    wire logic             wbReq   = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire logic             wbWrite = wbReq & wb_we_i & wb_sel_i[0];
    wire logic [7:0]       wbByte  = wb_dat_i[7:0];
    wire logic             alignWrite = wbWrite & (wbIdx == IDX_ALIGN_CONTROL)
                                        & wbByte[BIT_ALIGN_TRIGGER];
    wire logic             syncNow = syncReq_ff;

    // programmed stage fields, decoded from the register images
    logic [NUM_STAGES-1:0] progByp;
    logic [NUM_STAGES-1:0] dutyOn;
    logic [4:0]            progHi  [NUM_STAGES];
    logic [4:0]            progLo  [NUM_STAGES];
    logic [NUM_STAGES-1:0] advance;
    logic [NUM_STAGES-1:0] tick;
    logic [NUM_STAGES-1:0] lvl;

    // single-stage bypass in bit 7 of the second register
    assign progByp[0] = phaseReg_ff[0][BIT_BYPASS];
    assign progByp[1] = phaseReg_ff[1][BIT_BYPASS];
    assign progByp[2] = phaseReg_ff[2][BIT_BYPASS];
    // cascaded bypass bits 4 and 5
    assign progByp[3] = cascByp_ff[0][BIT_STAGE1_BYPASS];
    assign progByp[4] = cascByp_ff[0][BIT_STAGE2_BYPASS];
    assign progByp[5] = cascByp_ff[1][BIT_STAGE1_BYPASS];
    assign progByp[6] = cascByp_ff[1][BIT_STAGE2_BYPASS];

    // per-stage field split, advance strobe, rising tick and level
    for (genvar k = 0; k < NUM_STAGES; k++) begin : g_stage
        // one duty disable bit per channel serves both stages
        assign dutyOn[k] = ~dutyOff_ff[STAGE_CHAN[k]];
        assign {progHi[k], progLo[k]} = ratioSplit(countsReg_ff[k], dutyOn[k]);
        if (FIRST_STAGE_MASK[k]) begin : g_first
            // first stages count every distribution clock cycle
            assign advance[k] = 1'b1;
            assign lvl[k]     = actByp_ff[k] | out_ff[k];
        end else begin : g_second
            // second stage counts rising edges of the first, ratios multiply
            assign advance[k] = tick[k-1];
            assign lvl[k]     = actByp_ff[k] ? lvl[k-1] : out_ff[k];
        end
        assign tick[k] = advance[k] & (actByp_ff[k] | (~out_ff[k] & (cnt_ff[k] == 5'h00)));
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    function automatic logic [7:0] readByte(input logic [IDX_W-1:0] idx);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < NUM_STAGES; k++) begin
            if (idx == COUNT_IDX[k]) begin
                r = countsReg_ff[k];
            end
        end
        for (int c = 0; c < NUM_CHANS; c++) begin
            if (idx == PHASE_IDX[c]) begin
                r = phaseReg_ff[c];
            end
            if (idx == DUTY_IDX[c]) begin
                r = {7'h00, dutyOff_ff[c]};
            end
        end
        for (int b = 0; b < 2; b++) begin
            if (idx == CASC_BYPASS_IDX[b]) begin
                r = cascByp_ff[b];
            end
        end
        if (idx == IDX_SOURCE_SELECT) begin
            r = {6'h00, srcSel_ff};
        end
        if (idx == IDX_OUTPUT_ENABLE) begin
            r = {6'h00, outEnB_ff};
        end
        if (idx == IDX_STATUS) begin
            r = {3'h0, chanOut_ff};
        end
        return r;
    endfunction : readByte

    wire logic [31:0] rdWord = {24'h00_0000, readByte(wbIdx)};

    // ------------------------------------------------------------------
    // wishbone slave: one-cycle ack, unmapped reads zero, writes ignored
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_ff  <= 1'b0;
            datO_ff <= 32'h0000_0000;
        end else begin
            ack_ff  <= wbReq;
            datO_ff <= wbReq ? rdWord : 32'h0000_0000;
        end
    end

    // register writes; only byte lane 0 carries data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // duty fix active, B outputs off after reset
            dutyOff_ff <= {NUM_CHANS{RST_DUTY_OFF}};
            outEnB_ff  <= RST_OUT_ENABLE;
            srcSel_ff  <= RST_SOURCE;
            for (int k = 0; k < NUM_STAGES; k++) begin
                countsReg_ff[k] <= RST_COUNTS;
            end
            for (int c = 0; c < NUM_CHANS; c++) begin
                phaseReg_ff[c] <= RST_PHASE;
            end
            for (int b = 0; b < 2; b++) begin
                cascByp_ff[b] <= RST_CASC_BYPASS;
            end
        end else if (wbWrite) begin
            for (int k = 0; k < NUM_STAGES; k++) begin
                if (wbIdx == COUNT_IDX[k]) begin
                    countsReg_ff[k] <= wbByte;
                end
            end
            for (int c = 0; c < NUM_CHANS; c++) begin
                // begin_high bit 4, phase_skip bits 3:0
                if (wbIdx == PHASE_IDX[c]) begin
                    phaseReg_ff[c] <= (c < 3) ? (wbByte & 8'h9f) : (wbByte & 8'h1f);
                end
                if (wbIdx == DUTY_IDX[c]) begin
                    dutyOff_ff[c] <= wbByte[BIT_DUTY_FIX_DISABLE];
                end
            end
            for (int b = 0; b < 2; b++) begin
                if (wbIdx == CASC_BYPASS_IDX[b]) begin
                    cascByp_ff[b] <= wbByte & 8'h30;
                end
            end
            // forbidden source code leaves the selector unchanged
            if (wbIdx == IDX_SOURCE_SELECT && wbByte[1:0] != SRC_FORBIDDEN) begin
                srcSel_ff <= source_sel_t'(wbByte[1:0]);
            end
            if (wbIdx == IDX_OUTPUT_ENABLE) begin
                outEnB_ff <= wbByte[1:0];
            end
        end
    end

    // alignment request; reset itself counts as one so outputs start aligned
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            syncReq_ff <= 1'b1;
        end else begin
            // offsets are applied only through this event
            syncReq_ff <= alignWrite | alignTrigger;
        end
    end

    // ------------------------------------------------------------------
    // divider next state
    // ------------------------------------------------------------------
    always_comb begin
        for (int k = 0; k < NUM_STAGES; k++) begin
            logic [3:0] skip;
            logic       beginHigh;
            skip      = phaseReg_ff[STAGE_CHAN[k]][3:0];
            beginHigh = phaseReg_ff[STAGE_CHAN[k]][BIT_BEGIN_HIGH];
            nxt_cnt[k]    = cnt_ff[k];
            nxt_out[k]    = out_ff[k];
            nxt_actHi[k]  = actHi_ff[k];
            nxt_actLo[k]  = actLo_ff[k];
            nxt_actByp[k] = actByp_ff[k];
            if (syncNow) begin
                // every stage reloads in the same cycle
                nxt_actHi[k]  = progHi[k];
                nxt_actLo[k]  = progLo[k];
                nxt_actByp[k] = progByp[k];
                nxt_out[k]    = 1'b0;
                nxt_cnt[k]    = 5'h00;
                if (FIRST_STAGE_MASK[k] && !progByp[k]) begin
                    // begin_high weighs 16 over the four skip bits
                    if (beginHigh && skip != 4'h0) begin
                        // begin high, high skip plus one cycles, then full low
                        nxt_out[k] = 1'b1;
                        nxt_cnt[k] = {1'b0, skip};
                    end else if (beginHigh) begin
                        // skip of zero: delay is the low length
                        nxt_cnt[k] = progLo[k];
                    end else begin
                        // plain delay of skip input cycles
                        nxt_cnt[k] = {1'b0, skip};
                    end
                end
            end else if (advance[k] && !actByp_ff[k]) begin
                if (cnt_ff[k] != 5'h00) begin
                    nxt_cnt[k] = cnt_ff[k] - 5'h01;
                end else if (out_ff[k]) begin
                    // low phase of actLo cycles, low field plus one only with duty fix off
                    nxt_out[k] = 1'b0;
                    nxt_cnt[k] = actLo_ff[k] - 5'h01;
                end else begin
                    // new ratio taken only at the period start
                    nxt_out[k]    = 1'b1;
                    nxt_cnt[k]    = progHi[k] - 5'h01;
                    nxt_actHi[k]  = progHi[k];
                    nxt_actLo[k]  = progLo[k];
                    nxt_actByp[k] = progByp[k];
                end
            end else if (tick[k]) begin
                // bypassed stage keeps its counter still
                nxt_actHi[k]  = progHi[k];
                nxt_actLo[k]  = progLo[k];
                nxt_actByp[k] = progByp[k];
            end
        end
    end

    // divider state registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            actByp_ff <= '0;
            for (int k = 0; k < NUM_STAGES; k++) begin
                cnt_ff[k]   <= 5'h00;
                out_ff[k]   <= 1'b0;
                actHi_ff[k] <= 5'h01;
                actLo_ff[k] <= 5'h01;
            end
        end else begin
            actByp_ff <= nxt_actByp;
            for (int k = 0; k < NUM_STAGES; k++) begin
                cnt_ff[k]   <= nxt_cnt[k];
                out_ff[k]   <= nxt_out[k];
                actHi_ff[k] <= nxt_actHi[k];
                actLo_ff[k] <= nxt_actLo[k];
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs, one flop after the stage levels
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chanOut_ff  <= '0;
            chanOutB_ff <= 2'h0;
        end else begin
            for (int c = 0; c < NUM_CHANS; c++) begin
                // a bypassed second stage passes the first stage level
                chanOut_ff[c] <= lvl[CHAN_LAST[c]];
            end
            // B outputs follow the channel only when enabled
            chanOutB_ff <= {lvl[6], lvl[4]} & outEnB_ff;
        end
    end

    assign wb_ack_o  = ack_ff;
    assign wb_dat_o  = datO_ff;
    assign chanOut   = chanOut_ff;
    assign chanOutB  = chanOutB_ff;
    assign sourceSel = srcSel_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // high phase length loaded at the rising edge
    a_high_phase_load: assert property (!syncNow && advance[0] && !actByp_ff[0] && tick[0]
        |=> out_ff[0] && cnt_ff[0] == actHi_ff[0] - 5'h01)
        else $error("high phase length wrong");
    // uncorrected ratio: fields 3 and 2 give 3 high then 4 low
    a_ratio_split: assert property (dutyOff_ff[0] && countsReg_ff[0] == 8'h32
        |-> progHi[0] == 5'h03 && progLo[0] == 5'h04)
        else $error("ratio split wrong");
    a_bypass_frozen: assert property (!syncNow && actByp_ff[0] |=> $stable(cnt_ff[0]))
        else $error("bypassed counter moved");
    a_duty_reset: assert property ($fell(rst) |-> dutyOff_ff == '0)
        else $error("duty fix not on after reset");
    a_duty_even: assert property (!dutyOff_ff[2] && countsReg_ff[2] == 8'h51
        |-> progHi[2] == 5'h04 && progLo[2] == 5'h04)
        else $error("corrected split not even");
    a_skip_low: assert property (syncNow && !progByp[0] && !phaseReg_ff[0][BIT_BEGIN_HIGH]
        |=> !out_ff[0] && cnt_ff[0] == {1'b0, $past(phaseReg_ff[0][3:0])})
        else $error("skip delay not loaded");
    // begin high with skip falls after skip plus one cycles
    a_begin_high: assert property (syncNow && !progByp[1] && phaseReg_ff[1][4:0] == 5'h13
        |=> out_ff[1] ##1 out_ff[1] ##1 out_ff[1] ##1 out_ff[1] ##1 !out_ff[1])
        else $error("begin high timing wrong");
    // both cascaded stages bypassed hold the output high
    a_casc_bypass: assert property (actByp_ff[3] && actByp_ff[4] |=> chanOut_ff[3])
        else $error("double bypass not ratio one");
    a_b_output_off: assert property ($fell(rst) |-> outEnB_ff == 2'h0)
        else $error("B output enabled after reset");
    a_source_legal: assert property (srcSel_ff != SRC_FORBIDDEN)
        else $error("forbidden source selected");
    // active ratio held between period starts
    a_ratio_hold: assert property (!syncNow && !tick[0] |=> $stable(actLo_ff[0]))
        else $error("ratio changed mid period");

endmodule : channel_clock_divider
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
module tb_top
    import channel_clock_divider_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_sys = 0, rst = 1, cyc = 0, stb = 0, we = 0, algn = 0;
    logic [10:0] adr  = '0;
    logic [3:0]  sel  = '0;
    logic [31:0] wdat = '0, rdat;
    logic        ack;
    logic [4:0]  chanOut;
    logic [1:0]  chanOutB, sourceSel;
    int          errors = 0, nTests = 0, cycleCount = 0;
    int          ch, hi, lo, d, e, n, bh, sk, sawB;
    logic [7:0]  v;

    channel_clock_divider DUT (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .alignTrigger(algn), .chanOut(chanOut), .chanOutB(chanOutB),
        .sourceSel(sourceSel));

    // ----------------------------------------------------------------
    // clock, hang guard, shared tasks
    // ----------------------------------------------------------------
    always #12.5 clk_sys = ~clk_sys;
    // ceiling well above the longest run of the sequence below
    always @(posedge clk_sys) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 60000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
        nTests++;
        if (act !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, act);
        end
    endtask : chk
    // divide ratio of one stage from its packed low and high fields
    function automatic int ratio(input logic [7:0] f);
        return f[7:4] + f[3:0] + 2;
    endfunction : ratio
    // one classic cycle; request held until ack is seen at an edge
    task automatic wb(input logic w, input logic [8:0] idx, input logic [7:0] dw,
                      output logic [7:0] q);
        @(posedge clk_sys);
        cyc <= 1; stb <= 1; we <= w; adr <= {idx, 2'b00}; wdat <= 32'(dw); sel <= 4'hf;
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 0; stb <= 0;
    endtask : wb
    task automatic wr(input logic [8:0] idx, input logic [7:0] dw);
        logic [7:0] q;
        wb(1'b1, idx, dw, q);
    endtask : wr
    task automatic rd(input logic [8:0] idx, input logic [7:0] ex);
        logic [7:0] q;
        wb(1'b0, idx, 8'h00, q);
        chk("register", 32'(ex), 32'(q));
    endtask : rd
    task automatic align();
        @(posedge clk_sys); algn <= 1;
        @(posedge clk_sys); algn <= 0;
    endtask : align
    // one full period from a rising edge; bounded so a stuck output ends
    task automatic meas(input int c, output int h, output int l);
        int k;
        k = 0; h = 0; l = 0;
        // let a fresh alignment reach the pins before timing edges
        repeat (4) @(posedge clk_sys);
        while (chanOut[c] !== 1'b0 && k < 3000) begin @(posedge clk_sys); k++; end
        while (chanOut[c] !== 1'b1 && k < 3000) begin @(posedge clk_sys); k++; end
        while (chanOut[c] === 1'b1 && k < 3000) begin @(posedge clk_sys); h++; k++; end
        while (chanOut[c] === 1'b0 && k < 3000) begin @(posedge clk_sys); l++; k++; end
    endtask : meas
    // cycles from a channel 0 rise to the next channel 1 rise, after settling
    task automatic phase_diff(output int df);
        logic [4:0] p;
        int         k;
        repeat (40) @(posedge clk_sys);
        p = chanOut; k = -1; df = -1;
        repeat (40) begin
            @(posedge clk_sys);
            if (chanOut[0] & ~p[0]) k = 0; else if (k >= 0) k++;
            if (k >= 0 && (chanOut[1] & ~p[1]) && df < 0) df = k;
            p = chanOut;
        end
    endtask : phase_diff
    task automatic wrap_up();
        $display("checks %0d errors %0d", nTests, errors);
        if (errors == 0 && nTests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(9));
        repeat (6) @(posedge clk_sys);
        rst <= 0;
        for (int i = 0; i < NUM_CHANS; i++) begin
            rd(DUTY_IDX[i], 8'h00);
            rd(COUNT_IDX[i], 8'h00);
        end
        chk("sourceSel", 2'b10, sourceSel);
        chk("chanOutB", 2'b00, chanOutB);
        meas(3, hi, lo);
        chk("casc period", 4, hi + lo);
        // single stages: corners of full fields, 3/4 split, even 8, then random
        for (int i = 0; i < 8; i++) begin
            ch = (i < 3) ? (i & 2) : $urandom_range(2);
            v = (i == 0) ? 8'hff : (i == 1) ? 8'h32 : (i == 2) ? 8'h51 : 8'($urandom);
            n = v[3:0]; d = ratio(v);
            wr(COUNT_IDX[ch], v);
            wr(DUTY_IDX[ch], 8'(i % 2));
            align();
            meas(ch, hi, lo);
            chk("high", (i % 2) ? n + 1 : d / 2, hi);
            chk("period", d, hi + lo);
        end
        // cascaded channels 3 and 4: product, then second stage bypassed
        for (int j = 3; j < 5; j++) begin
            v = 8'($urandom); wr(COUNT_IDX[2 * j - 3], v);
            e = ratio(v);
            v = 8'($urandom); wr(COUNT_IDX[2 * j - 2], v);
            align();
            meas(j, hi, lo);
            chk("casc period", e * ratio(v), hi + lo);
            wr(CASC_BYPASS_IDX[j - 3], 8'h20);
            align();
            meas(j, hi, lo);
            chk("casc bypass2", e, hi + lo);
            wr(CASC_BYPASS_IDX[j - 3], 8'h00);
        end
        // bypassed single stage and doubly bypassed cascade both stand high
        wr(PHASE_IDX[0], 8'h80);
        wr(CASC_BYPASS_IDX[0], 8'h30);
        align();
        repeat (10) @(posedge clk_sys);
        meas(0, hi, lo);
        chk("bypass", 1, {lo != 0, chanOut[0]});
        meas(3, hi, lo);
        chk("casc bypass both", 1, {lo != 0, chanOut[3]});
        wr(CASC_BYPASS_IDX[0], 8'h00);
        // coarse delay between channels 0 and 1, period 8
        for (int i = 0; i < 4; i++) begin
            bh = i / 2; sk = (i == 2) ? 3 : $urandom_range(15, 1);
            for (int c = 0; c < 2; c++) begin
                wr(COUNT_IDX[c], 8'h33); wr(DUTY_IDX[c], 8'h01);
            end
            wr(PHASE_IDX[0], 8'h00);
            wr(PHASE_IDX[1], 8'((bh << 4) | sk));
            e = (bh ? sk + 4 : sk) % 8;
            // alternate the register trigger with the pin trigger
            if (i % 2) wr(IDX_ALIGN_CONTROL, 8'h01);
            else align();
            phase_diff(d);
            chk("phase", e, d);
            wr(PHASE_IDX[1], 8'h00);
            phase_diff(d);
            chk("phase held", e, d);
            align();
        end
        // source codes; forbidden code leaves the selection alone
        for (int i = 0; i < 4; i++) begin
            wr(IDX_SOURCE_SELECT, 8'(i));
            chk("sourceSel", (i == 3) ? 2 : i, sourceSel);
        end
        wr(9'h100, 8'h5a);
        rd(9'h100, 8'h00);
        // B outputs only after enabling
        wr(IDX_OUTPUT_ENABLE, 8'h01);
        // restart so a long channel 3 period still rises inside the window
        align();
        sawB = 0;
        repeat (64) begin
            @(posedge clk_sys);
            if (chanOutB[0] === 1'b1) sawB |= 1;
            if (chanOutB[1] !== 1'b0) sawB |= 2;
        end
        chk("chanOutB", 1, sawB);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
